// >>> design/eag_limit_reg.sv
// Stack limit holding register with bit 0 forced clear
`timescale 1ns/10ps
`default_nettype none
module eag_limit_reg
  import eag_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  initial begin
    if (WIDTH < 2) $error("eag_limit_reg: WIDTH too small");
  end

  logic [WIDTH-1:0] lim_q;

  // No reset: contents stay undefined until software loads a value
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      lim_q <= wr_data;
    end
  end

  always_comb begin
    rd_data = lim_q;
    rd_data[SLIM_BIT0_POS] = 1'b0;
  end
endmodule // eag_limit_reg
`default_nettype wire

// >>> design/eag_pkg.sv
// Package: constants and types for the effective-address and stack-check block
package eag_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NEAR_ADDR_W = 13;
  localparam int unsigned SHORT_LIT_W = 5;
  localparam int unsigned LONG_LIT_W = 10;
  localparam int unsigned DEFAULT_WORK_ALIAS_SEL_W = 4;
  localparam logic [3:0] DEFAULT_WORK_IDX = 4'h0;
  localparam logic [3:0] STACK_PTR_IDX = 4'hf;
  localparam logic [15:0] STACK_FLOOR_ADDR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int unsigned SLIM_BIT0_POS = 0;
  localparam logic [15:0] SLIM_RESET_VAL = 16'h0000;

  typedef enum logic [3:0] {
    EAG_MODE_FILE,
    EAG_MODE_FILE_ANY,
    EAG_MODE_REG_DIRECT,
    EAG_MODE_IND,
    EAG_MODE_IND_POST,
    EAG_MODE_IND_PRE,
    EAG_MODE_INDEXED,
    EAG_MODE_LIT_OFFSET,
    EAG_MODE_LIT5,
    EAG_MODE_LIT10,
    EAG_MODE_PUSH,
    EAG_MODE_POP,
    EAG_MODE_PUSH_CALL_PC,
    EAG_MODE_PUSH_EXC_PC
  } eag_mode_e;

  typedef enum logic [1:0] {
    EAG_DST_SAME_FILE,
    EAG_DST_DEFAULT_WORK,
    EAG_DST_WORK_PAIR
  } eag_dst_e;
endpackage

// >>> design/eag_stack_ea.sv
// Effective-address generator with stack limit and underflow checking
`timescale 1ns/10ps
`default_nettype none
module eag_stack_ea
  import eag_pkg::*;
#(
  parameter int unsigned AW = DATA_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Request from instruction decode, one per cycle while req_valid
  input wire logic req_valid,
  input wire eag_mode_e req_mode,
  input wire logic req_is_mul,
  input wire logic req_dst_work,
  input wire logic [NEAR_ADDR_W-1:0] req_near_addr,
  input wire logic [AW-1:0] req_full_addr,
  input wire logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] req_ptr_sel,
  input wire logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] req_base_sel,
  input wire logic signed [AW-1:0] req_mod_const,
  input wire logic [LONG_LIT_W-1:0] req_literal,
  input wire logic [AW-1:0] req_push_data,
  input wire logic [AW-1:0] req_pc,
  input wire logic [7:0] status_low_byte,
  // Working register file view
  input wire logic [AW-1:0] pointer_work_reg,
  input wire logic [AW-1:0] base_work_reg,
  input wire logic [AW-1:0] default_work_reg,
  input wire logic [AW-1:0] stack_pointer_reg,
  // Stack limit load from the register write path
  input wire logic stack_limit_wr,
  input wire logic [AW-1:0] stack_limit_wdata,
  output logic [AW-1:0] stack_limit_reg,
  // Results
  output logic ea_valid,
  output logic [AW-1:0] ea_addr,
  output logic ea_is_mem,
  output logic [AW-1:0] operand_lit,
  output logic [AW-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] src1_sel,
  output logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] ea_ptr_sel,
  output eag_dst_e dst_kind,
  output logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] dst_work_sel,
  output logic ptr_wb_en,
  output logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] ptr_wb_sel,
  output logic [AW-1:0] ptr_wb_data,
  output logic stack_ovf_trap,
  output logic stack_unf_trap
);
  initial begin
    if (AW != DATA_W) $error("eag_stack_ea: AW must equal DATA_W");
  end

  typedef struct packed {
    logic ea_valid;
    logic [AW-1:0] ea_addr;
    logic ea_is_mem;
    logic [AW-1:0] operand_lit;
    logic [AW-1:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] src1_sel;
    logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] ea_ptr_sel;
    eag_dst_e dst_kind;
    logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] dst_work_sel;
    logic ptr_wb_en;
    logic [DEFAULT_WORK_ALIAS_SEL_W-1:0] ptr_wb_sel;
    logic [AW-1:0] ptr_wb_data;
    logic ovf;
    logic unf;
  } eag_state_s;

  eag_state_s st_q;
  eag_state_s st_d;
  logic [AW-1:0] lim_rd;
  logic [AW-1:0] ptr_mod;
  logic [AW-1:0] sp_dec;
  logic [AW-1:0] sp_inc;
  logic [AW-1:0] stack_ea;
  logic stack_use;
  logic is_push;

  eag_limit_reg #(
    .WIDTH(AW)
  ) u_limit (
    .core_clk(core_clk),
    .wr_en(stack_limit_wr),
    .wr_data(stack_limit_wdata),
    .rd_data(lim_rd)
  );

  assign stack_limit_reg = lim_rd;
  assign ptr_mod = pointer_work_reg + req_mod_const;
  assign sp_dec = stack_pointer_reg - WORD_STEP;
  assign sp_inc = stack_pointer_reg + WORD_STEP;

  always_comb begin
    st_d = st_q;
    st_d.ea_valid = 1'b0;
    st_d.mem_we = 1'b0;
    st_d.mem_re = 1'b0;
    st_d.ptr_wb_en = 1'b0;
    st_d.ovf = 1'b0;
    st_d.unf = 1'b0;
    stack_use = 1'b0;
    is_push = 1'b0;
    stack_ea = '0;
    if (req_valid) begin
      st_d.ea_valid = 1'b1;
      st_d.ea_is_mem = 1'b1;
      st_d.src1_sel = req_base_sel;
      st_d.ea_ptr_sel = req_ptr_sel;
      st_d.dst_kind = EAG_DST_SAME_FILE;
      st_d.dst_work_sel = req_ptr_sel;
      st_d.operand_lit = '0;
      st_d.ptr_wb_sel = req_ptr_sel;
      st_d.mem_wdata = req_push_data;
      unique case (req_mode)
        EAG_MODE_FILE: begin
          st_d.ea_addr = {{(AW-NEAR_ADDR_W){1'b0}}, req_near_addr};
          st_d.src1_sel = DEFAULT_WORK_IDX;
          st_d.mem_re = 1'b1;
          if (req_is_mul) begin
            st_d.dst_kind = EAG_DST_WORK_PAIR;
          end else if (req_dst_work) begin
            st_d.dst_kind = EAG_DST_DEFAULT_WORK;
            st_d.dst_work_sel = DEFAULT_WORK_IDX;
          end
        end
        EAG_MODE_FILE_ANY: begin
          st_d.ea_addr = req_full_addr;
          st_d.mem_re = 1'b1;
        end
        EAG_MODE_REG_DIRECT: begin
          st_d.ea_is_mem = 1'b0;
          st_d.ea_addr = '0;
        end
        EAG_MODE_IND: begin
          st_d.ea_addr = pointer_work_reg;
          st_d.mem_re = 1'b1;
        end
        EAG_MODE_IND_POST: begin
          st_d.ea_addr = pointer_work_reg;
          st_d.mem_re = 1'b1;
          st_d.ptr_wb_en = 1'b1;
          st_d.ptr_wb_data = ptr_mod;
        end
        EAG_MODE_IND_PRE: begin
          st_d.ea_addr = ptr_mod;
          st_d.mem_re = 1'b1;
          st_d.ptr_wb_en = 1'b1;
          st_d.ptr_wb_data = ptr_mod;
        end
        EAG_MODE_INDEXED: begin
          st_d.ea_addr = pointer_work_reg + base_work_reg;
          st_d.mem_re = 1'b1;
        end
        EAG_MODE_LIT_OFFSET: begin
          st_d.ea_addr = pointer_work_reg + {{(AW-LONG_LIT_W){1'b0}}, req_literal};
          st_d.mem_re = 1'b1;
        end
        EAG_MODE_LIT5: begin
          st_d.ea_is_mem = 1'b0;
          st_d.ea_addr = '0;
          st_d.operand_lit = {{(AW-SHORT_LIT_W){1'b0}}, req_literal[SHORT_LIT_W-1:0]};
        end
        EAG_MODE_LIT10: begin
          st_d.ea_is_mem = 1'b0;
          st_d.ea_addr = '0;
          st_d.operand_lit = {{(AW-LONG_LIT_W){1'b0}}, req_literal};
        end
        EAG_MODE_POP: begin
          st_d.ea_addr = sp_dec;
          st_d.mem_re = 1'b1;
          st_d.ptr_wb_en = 1'b1;
          st_d.ptr_wb_sel = STACK_PTR_IDX;
          st_d.ptr_wb_data = sp_dec;
        end
        EAG_MODE_PUSH, EAG_MODE_PUSH_CALL_PC, EAG_MODE_PUSH_EXC_PC: begin
          is_push = 1'b1;
          st_d.ea_addr = stack_pointer_reg;
          st_d.mem_we = 1'b1;
          st_d.ptr_wb_en = 1'b1;
          st_d.ptr_wb_sel = STACK_PTR_IDX;
          st_d.ptr_wb_data = sp_inc;
          if (req_mode == EAG_MODE_PUSH_CALL_PC) begin
            st_d.mem_wdata = {1'b0, req_pc[AW-2:0]};
          end else if (req_mode == EAG_MODE_PUSH_EXC_PC) begin
            st_d.mem_wdata = {status_low_byte, req_pc[7:0]};
          end
        end
        default: begin
          st_d.ea_valid = 1'b0;
          st_d.ea_is_mem = 1'b0;
        end
      endcase
      // Accesses using the stack pointer as pointer register are checked too, not only push and pop (a stack-pointer base is not)
      if (req_mode inside {EAG_MODE_PUSH, EAG_MODE_PUSH_CALL_PC, EAG_MODE_PUSH_EXC_PC,
                           EAG_MODE_POP}) begin
        stack_use = 1'b1;
        stack_ea = st_d.ea_addr;
      end else if (req_ptr_sel == STACK_PTR_IDX && req_mode inside {EAG_MODE_IND,
                   EAG_MODE_IND_POST, EAG_MODE_IND_PRE, EAG_MODE_INDEXED,
                   EAG_MODE_LIT_OFFSET}) begin
        stack_use = 1'b1;
        stack_ea = st_d.ea_addr;
      end
      // Push at the limit itself is allowed; only beyond it traps
      if (stack_use && (is_push ? (stack_ea > lim_rd) : (stack_ea > lim_rd))) begin
        st_d.ovf = 1'b1;
      end
      if (stack_use && stack_ea < STACK_FLOOR_ADDR) begin
        st_d.unf = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ea_valid = st_q.ea_valid;
  assign ea_addr = st_q.ea_addr;
  assign ea_is_mem = st_q.ea_is_mem;
  assign operand_lit = st_q.operand_lit;
  assign mem_wdata = st_q.mem_wdata;
  assign mem_we = st_q.mem_we;
  assign mem_re = st_q.mem_re;
  assign src1_sel = st_q.src1_sel;
  assign ea_ptr_sel = st_q.ea_ptr_sel;
  assign dst_kind = st_q.dst_kind;
  assign dst_work_sel = st_q.dst_work_sel;
  assign ptr_wb_en = st_q.ptr_wb_en;
  assign ptr_wb_sel = st_q.ptr_wb_sel;
  assign ptr_wb_data = st_q.ptr_wb_data;
  assign stack_ovf_trap = st_q.ovf;
  assign stack_unf_trap = st_q.unf;
endmodule // eag_stack_ea
`default_nettype wire

// >>> sim/eag_regs_model.sv
// Register file stand-in that owns the stack pointer
`timescale 1ns/10ps
`default_nettype none
module eag_regs_model
  import eag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ld,
  input wire logic [15:0] ld_val,
  input wire logic ptr_wb_en,
  input wire logic [3:0] ptr_wb_sel,
  input wire logic [15:0] ptr_wb_data,
  output logic [15:0] stack_pointer_reg
);
  // Writeback lands one edge after the answer, so dependent requests need a gap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) stack_pointer_reg <= 16'h0800;
    else if (ld) stack_pointer_reg <= ld_val;
    else if (ptr_wb_en && ptr_wb_sel == STACK_PTR_IDX) stack_pointer_reg <= ptr_wb_data;
  end
endmodule // eag_regs_model
`default_nettype wire

// >>> sim/eag_stack_ea_props.sv
// Checker for address results and stack trap timing
`timescale 1ns/10ps
`default_nettype none
module eag_stack_ea_props
  import eag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire eag_mode_e req_mode,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic [15:0] pointer_work_reg,
  input wire logic [15:0] base_work_reg,
  input wire logic signed [15:0] req_mod_const,
  input wire logic [15:0] stack_limit_reg,
  input wire logic ea_valid,
  input wire logic [15:0] ea_addr,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] ptr_wb_data,
  input wire logic stack_ovf_trap,
  input wire logic stack_unf_trap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req(eag_mode_e m);
    req_valid && req_mode == m;
  endsequence
  AST_PUSH: assert property (s_req(EAG_MODE_PUSH) |=> mem_we
    && ea_addr == $past(stack_pointer_reg) && ptr_wb_data == ea_addr + WORD_STEP)
    else $error("push address or step wrong");
  AST_POP: assert property (s_req(EAG_MODE_POP) |=> mem_re
    && ea_addr == $past(stack_pointer_reg) - WORD_STEP && ptr_wb_data == ea_addr)
    else $error("pop address or step wrong");
  AST_OVF: assert property (s_req(EAG_MODE_PUSH) |=>
    stack_ovf_trap == ($past(stack_pointer_reg) > $past(stack_limit_reg)))
    else $error("overflow trap wrong");
  AST_UNF: assert property (s_req(EAG_MODE_POP) |=>
    stack_unf_trap == (ea_addr < STACK_FLOOR_ADDR)) else $error("underflow trap wrong");
  AST_IND: assert property (s_req(EAG_MODE_IND) |=>
    ea_addr == $past(pointer_work_reg)) else $error("indirect address wrong");
  AST_POST: assert property (s_req(EAG_MODE_IND_POST) |=> ea_addr == $past(pointer_work_reg)
    && ptr_wb_data == ea_addr + $past(req_mod_const)) else $error("post-modify wrong");
  AST_PRE: assert property (s_req(EAG_MODE_IND_PRE) |=> ptr_wb_data == ea_addr
    && ea_addr == $past(pointer_work_reg) + $past(req_mod_const)) else $error("pre-modify wrong");
  AST_IDX: assert property (s_req(EAG_MODE_INDEXED) |=>
    ea_addr == $past(pointer_work_reg) + $past(base_work_reg)) else $error("indexed wrong");
  AST_IDLE: assert property (!req_valid |=>
    !ea_valid && !stack_ovf_trap && !stack_unf_trap) else $error("output without request");
  AST_LIM0: assert property (stack_limit_reg[0] == 1'b0)
    else $error("limit bit 0 set");
endmodule // eag_stack_ea_props
bind eag_stack_ea eag_stack_ea_props eag_stack_ea_props_i(.*);
`default_nettype wire

// >>> sim/eag_stack_ea_tb.sv
// Testbench for the address generator and stack checks
`timescale 1ns/10ps
`default_nettype none
module eag_stack_ea_tb
  import eag_pkg::*;
;
  logic core_clk = 0, rst_b = 0, req_valid = 0, req_is_mul = 0, req_dst_work = 0;
  logic ld = 0, stack_limit_wr = 0, ea_valid, ea_is_mem, mem_we, mem_re, ptr_wb_en;
  logic stack_ovf_trap, stack_unf_trap;
  eag_mode_e req_mode = EAG_MODE_FILE;
  eag_dst_e dst_kind;
  logic [12:0] req_near_addr = 13'h1fff;
  logic [3:0] req_ptr_sel = 4'hf, req_base_sel = 4'h2, src1_sel, ea_ptr_sel, dst_work_sel;
  logic [3:0] ptr_wb_sel;
  logic [9:0] req_literal = 10'h3ff;
  logic [7:0] status_low_byte = 8'ha5;
  logic signed [15:0] req_mod_const = 16'hfffe;
  logic [15:0] req_full_addr = 16'hfffe, req_push_data = 16'h1357, req_pc = 16'hffff;
  logic [15:0] pointer_work_reg = 16'h1000, base_work_reg = 16'h0030;
  logic [15:0] default_work_reg = 16'h0000, stack_limit_wdata = 16'h0805, ld_val = 16'h0000;
  logic [15:0] stack_pointer_reg, stack_limit_reg, ea_addr, operand_lit, mem_wdata, ptr_wb_data;
  int n_tests = 0, n_mismatch = 0;
  eag_stack_ea #(.AW(16)) eag_stack_ea_i(.*);
  eag_regs_model eag_regs_model_i(.*);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answer is registered, so it is judged at the falling edge after the request edge
  task automatic go(input eag_mode_e m);
    @(negedge core_clk);
    req_mode = m;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic set_sp(input logic [15:0] v);
    @(negedge core_clk);
    ld = 1'b1;
    ld_val = v;
    @(negedge core_clk);
    ld = 1'b0;
  endtask
  task automatic t_limit;
    @(negedge core_clk);
    stack_limit_wr = 1'b1;
    @(negedge core_clk);
    stack_limit_wr = 1'b0;
    chk(stack_limit_reg, 16'h0804);
    @(negedge core_clk);
    $display("t_limit done");
  endtask
  task automatic t_push;
    set_sp(16'h0802);
    go(EAG_MODE_PUSH);
    chk(ea_addr, 16'h0802);
    chk(ea_valid, 16'h0001);
    chk(mem_we, 16'h0001);
    chk(ptr_wb_en, 16'h0001);
    chk(ptr_wb_sel, 16'h000f);
    chk(mem_wdata, 16'h1357);
    chk(stack_ovf_trap, 16'h0000);
    go(EAG_MODE_PUSH);
    chk(stack_ovf_trap, 16'h0000);
    go(EAG_MODE_PUSH);
    chk(ea_addr, 16'h0806);
    chk(ptr_wb_data, 16'h0808);
    chk(stack_ovf_trap, 16'h0001);
    $display("t_push done");
  endtask
  task automatic t_pop;
    set_sp(16'h0802);
    go(EAG_MODE_POP);
    chk(ea_addr, 16'h0800);
    chk(mem_re, 16'h0001);
    chk(stack_unf_trap, 16'h0000);
    go(EAG_MODE_POP);
    chk(ea_addr, 16'h07fe);
    chk(stack_unf_trap, 16'h0001);
    $display("t_pop done");
  endtask
  task automatic t_pc;
    set_sp(16'h0900);
    go(EAG_MODE_PUSH_CALL_PC);
    chk(mem_wdata, 16'h7fff);
    req_pc = 16'h1234;
    go(EAG_MODE_PUSH_EXC_PC);
    chk(mem_wdata, 16'ha534);
    $display("t_pc done");
  endtask
  task automatic t_modes;
    eag_mode_e m[5] = '{EAG_MODE_IND, EAG_MODE_IND_POST, EAG_MODE_IND_PRE,
      EAG_MODE_INDEXED, EAG_MODE_LIT_OFFSET};
    logic [15:0] e[5] = '{16'h1000, 16'h1000, 16'h0ffe, 16'h1030, 16'h13ff};
    req_ptr_sel = 4'h3;
    for (int i = 0; i < 5; i++) begin
      go(m[i]);
      chk(ea_addr, e[i]);
      if (i == 1 || i == 2) chk(ptr_wb_data, 16'h0ffe);
    end
    // Stack pointer used as an ordinary pointer is checked as well
    req_ptr_sel = 4'hf;
    pointer_work_reg = 16'h07f0;
    go(EAG_MODE_IND);
    chk(stack_unf_trap, 16'h0001);
    pointer_work_reg = 16'h0900;
    go(EAG_MODE_IND);
    chk(stack_ovf_trap, 16'h0001);
    pointer_work_reg = 16'h1000;
    req_ptr_sel = 4'h3;
    $display("t_modes done");
  endtask
  task automatic t_file;
    req_dst_work = 1'b1;
    go(EAG_MODE_FILE);
    chk(ea_addr, 16'h1fff);
    chk(dst_kind, EAG_DST_DEFAULT_WORK);
    chk(dst_work_sel, 16'h0000);
    req_is_mul = 1'b1;
    go(EAG_MODE_FILE);
    chk(dst_kind, EAG_DST_WORK_PAIR);
    go(EAG_MODE_FILE_ANY);
    chk(ea_addr, 16'hfffe);
    go(EAG_MODE_REG_DIRECT);
    chk(src1_sel, 16'h0002);
    chk(ea_is_mem, 16'h0000);
    go(EAG_MODE_LIT5);
    chk(operand_lit, 16'h001f);
    go(EAG_MODE_LIT10);
    chk(operand_lit, 16'h03ff);
    @(negedge core_clk);
    chk(ea_valid, 16'h0000);
    $display("t_file done");
  endtask
  task automatic final_report;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    t_limit;
    t_push;
    t_pop;
    t_pc;
    t_modes;
    t_file;
    final_report;
  end
endmodule // eag_stack_ea_tb
`default_nettype wire
